// [core/srt_params.svh]
// constants for the serial register access target
`ifndef SRT_PARAMS_SVH
`define SRT_PARAMS_SVH
`define SRT_CLK_MHZ 250
`define SRT_TIMEOUT_US 14000
`define SRT_ADDR_PREFIX 3'h2
`define SRT_GEN_AUTO 7'h00
`define SRT_GEN_HOST 7'h30
`define SRT_ALERT_ADDR 7'h0C
`define SRT_MODE_AUTO 2'h0
`define SRT_SHORT_START 8'h00
`define SRT_BITS_PER_BYTE 4'h8
`define SRT_LAST_TX_BIT 4'h7
`define SRT_STRAP_WAIT 2'h3
`define SRT_PTR_STEP 8'h01
`endif

// [core/srt_pkg.sv]
// types for the serial register access target
package srt_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_HACK,
    ST_PASS
  } srt_state_t;
  typedef enum logic [1:0] {
    K_ADDR,
    K_REG,
    K_DATA
  } srt_kind_t;
endpackage

// [core/srt_target.sv]
// two-wire serial target giving a host byte access to the register map
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_target
  import srt_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `SRT_TIMEOUT_US * `SRT_CLK_MHZ,
  parameter int unsigned TMO_W = 22
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic strap_addr_bit3_i,
  input wire logic strap_addr_bit2_i,
  input wire logic strap_addr_bit1_i,
  input wire logic strap_addr_bit0_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic irq_active_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_waddr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_we_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;
  logic [1:0] mode_s;
  logic [3:0] strap_s;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pin_s1_r <= 8'hFF;
      pin_s2_r <= 8'hFF;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      pin_s1_r <= {scl_i, sda_i, mode_sel_i, strap_addr_bit3_i,
                   strap_addr_bit2_i, strap_addr_bit1_i,
                   strap_addr_bit0_i};
      pin_s2_r <= pin_s1_r;
      scl_d_r <= pin_s2_r[7];
      sda_d_r <= pin_s2_r[6];
    end
  end
  assign scl_s = pin_s2_r[7];
  assign sda_s = pin_s2_r[6];
  assign mode_s = pin_s2_r[5:4];
  assign strap_s = pin_s2_r[3:0];
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // straps settle through the synchroniser before they are frozen
  logic [1:0] strap_cnt_r;
  logic [3:0] own_lo_r;
  logic [6:0] own_addr;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      strap_cnt_r <= 2'h0;
      own_lo_r <= 4'h0;
    end else if (strap_cnt_r != `SRT_STRAP_WAIT) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      own_lo_r <= strap_s;
    end
  end
  assign own_addr = {`SRT_ADDR_PREFIX, own_lo_r};
  function automatic logic [6:0] gen_addr(input logic [1:0] mode);
    // only 00 selects autonomous; 01 and 11 are host-managed
    gen_addr = (mode == `SRT_MODE_AUTO) ? `SRT_GEN_AUTO
                                        : `SRT_GEN_HOST;
  endfunction
  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  srt_state_t state_r;
  srt_kind_t kind_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [3:0] bcnt_r;
  logic [7:0] ptr_r;
  logic ptr_valid_r;
  logic rd_mode_r;
  logic ara_r;
  logic hack_ok_r;
  logic tmo_r;
  logic byte_done;
  logic own_hit;
  logic gen_hit;
  logic ara_hit;
  logic rw_bit;
  assign byte_done = (state_r == ST_RX) && scl_fall &&
                     (bcnt_r == `SRT_BITS_PER_BYTE);
  assign rw_bit = shift_r[0];
  assign own_hit = (shift_r[7:1] == own_addr);
  assign gen_hit = (shift_r[7:1] == gen_addr(mode_s));
  assign ara_hit = (shift_r[7:1] == `SRT_ALERT_ADDR) &&
                   (mode_s != `SRT_MODE_AUTO);
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      kind_r <= K_ADDR;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      bcnt_r <= 4'h0;
      ptr_r <= 8'h00;
      ptr_valid_r <= 1'b0;
      rd_mode_r <= 1'b0;
      ara_r <= 1'b0;
      hack_ok_r <= 1'b0;
      sda_oe_o <= 1'b0;
      reg_we_o <= 1'b0;
      reg_waddr_o <= 8'h00;
      reg_wdata_o <= 8'h00;
    end else begin
      reg_we_o <= 1'b0;
      if (tmo_r || stop_det) begin
        state_r <= ST_IDLE;
        sda_oe_o <= 1'b0;
        ptr_valid_r <= 1'b0;
      end else if (start_det && state_r != ST_PASS) begin
        // repeated start keeps the pointer loaded earlier
        state_r <= ST_RX;
        kind_r <= K_ADDR;
        bcnt_r <= 4'h0;
        sda_oe_o <= 1'b0;
        rd_mode_r <= 1'b0;
        ara_r <= 1'b0;
      end else begin
        case (state_r)
          ST_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bcnt_r <= bcnt_r + 4'h1;
            end else if (byte_done) begin
              state_r <= ST_ACK;
              sda_oe_o <= 1'b1;
              case (kind_r)
                K_ADDR: begin
                  if (own_hit) begin
                    rd_mode_r <= rw_bit;
                    kind_r <= K_REG;
                    if (rw_bit && !ptr_valid_r) begin
                      ptr_r <= `SRT_SHORT_START;
                    end
                  end else if (gen_hit && !rw_bit) begin
                    kind_r <= K_REG;
                  end else if (ara_hit && rw_bit && irq_active_i) begin
                    rd_mode_r <= 1'b1;
                    ara_r <= 1'b1;
                  end else begin
                    state_r <= ST_PASS;
                    sda_oe_o <= 1'b0;
                  end
                end
                K_REG: begin
                  ptr_r <= shift_r;
                  ptr_valid_r <= 1'b1;
                  kind_r <= K_DATA;
                end
                default: begin
                  reg_we_o <= 1'b1;
                  reg_waddr_o <= ptr_r;
                  reg_wdata_o <= shift_r;
                  ptr_r <= ptr_r + `SRT_PTR_STEP;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bcnt_r <= 4'h0;
              if (rd_mode_r) begin
                state_r <= ST_TX;
                if (ara_r) begin
                  tx_r <= {own_addr, 1'b0};
                  sda_oe_o <= ~own_addr[6];
                end else begin
                  tx_r <= reg_rdata_i;
                  sda_oe_o <= ~reg_rdata_i[7];
                  ptr_r <= ptr_r + `SRT_PTR_STEP;
                end
              end else begin
                state_r <= ST_RX;
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bcnt_r == `SRT_LAST_TX_BIT) begin
                state_r <= ST_HACK;
                hack_ok_r <= 1'b0;
                sda_oe_o <= 1'b0;
              end else begin
                bcnt_r <= bcnt_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_o <= ~tx_r[6];
              end
            end
          end
          ST_HACK: begin
            if (scl_rise) begin
              // a low line here means the host wants another byte
              hack_ok_r <= ~sda_s;
              if (sda_s || ara_r) begin
                state_r <= ST_PASS;
              end
            end else if (scl_fall && hack_ok_r) begin
              state_r <= ST_TX;
              bcnt_r <= 4'h0;
              tx_r <= reg_rdata_i;
              sda_oe_o <= ~reg_rdata_i[7];
              ptr_r <= ptr_r + `SRT_PTR_STEP;
            end
          end
          ST_PASS: begin
            sda_oe_o <= 1'b0;
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sda_o <= 1'b0;
      reg_addr_o <= 8'h00;
    end else begin
      // open drain: the line is only ever pulled low
      sda_o <= 1'b0;
      reg_addr_o <= ptr_r;
    end
  end
  // ----------------------------------------------------------------
  // stuck-clock timeout
  // ----------------------------------------------------------------
  // a wide counter, so simulations should shorten TIMEOUT_CYC
  logic [TMO_W-1:0] tmo_cnt_r;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tmo_cnt_r <= '0;
      tmo_r <= 1'b0;
    end else if (state_r == ST_IDLE || scl_rise || scl_fall || tmo_r) begin
      tmo_cnt_r <= '0;
      tmo_r <= 1'b0;
    end else if (tmo_cnt_r == TMO_W'(TIMEOUT_CYC - 1)) begin
      tmo_cnt_r <= '0;
      tmo_r <= 1'b1;
    end else begin
      tmo_cnt_r <= tmo_cnt_r + 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  pass_quiet_a: assert property (
    (state_r == ST_PASS) |-> !sda_oe_o)
    else $error("line driven while passive");
  addr_ack_a: assert property (
    (byte_done && kind_r == K_ADDR && own_hit && !stop_det && !tmo_r &&
     !start_det) |=> (state_r == ST_ACK && sda_oe_o))
    else $error("own address not acknowledged");
  ptr_load_a: assert property (
    (byte_done && kind_r == K_REG && !stop_det && !tmo_r && !start_det)
    |=> (ptr_r == $past(shift_r)))
    else $error("register pointer not loaded");
  write_data_a: assert property (
    reg_we_o |-> (reg_wdata_o == $past(shift_r) &&
                  reg_waddr_o == $past(ptr_r)))
    else $error("write data or address wrong");
  read_first_a: assert property (
    (state_r == ST_ACK && scl_fall && rd_mode_r && !ara_r && !stop_det &&
     !tmo_r && !start_det) |=> (sda_oe_o == !$past(reg_rdata_i[7])))
    else $error("first read bit not driven");
  ptr_step_a: assert property (
    reg_we_o |-> (ptr_r == 8'(reg_waddr_o + `SRT_PTR_STEP)))
    else $error("pointer not advanced after write");
  short_read_a: assert property (
    (byte_done && kind_r == K_ADDR && own_hit && rw_bit && !ptr_valid_r &&
     !stop_det && !tmo_r && !start_det) |=> (ptr_r == `SRT_SHORT_START))
    else $error("short read does not start at zero");
  bcast_read_a: assert property (
    (byte_done && kind_r == K_ADDR && gen_hit && !own_hit && !ara_hit &&
     rw_bit && !stop_det && !tmo_r && !start_det)
    |=> (state_r == ST_PASS && !sda_oe_o))
    else $error("broadcast read answered");
  timeout_idle_a: assert property (
    tmo_r |=> (state_r == ST_IDLE && !sda_oe_o))
    else $error("timeout did not abort");
  tmo_disarm_a: assert property (
    (state_r == ST_IDLE) [*2] |-> (tmo_cnt_r == '0 && !tmo_r))
    else $error("timeout running while idle");
  write_seen_c: cover property (reg_we_o ##[1:1000] reg_we_o);
  short_read_c: cover property (
    byte_done && kind_r == K_ADDR && own_hit && rw_bit && !ptr_valid_r);
  timeout_c: cover property (tmo_r);
endmodule // srt_target

// [testbench/srt_host.sv]
// host controller model driving the two-wire bus
`timescale 1ns/1ps
module srt_host (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // one scl high phase and half of a low phase, well above the target's sync delay
  localparam int H = 12;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // sda falls while scl high; also serves as repeated start
  task automatic start();
    sda_low_o = 1'b0;
    tick(H);
    scl_o = 1'b1;
    tick(H);
    sda_low_o = 1'b1;
    tick(H);
    scl_o = 1'b0;
    tick(H);
  endtask
  // the host ends a transfer with a stop; the target can also abort one on its stuck-clock timeout
  task automatic stop();
    sda_low_o = 1'b1;
    tick(H);
    scl_o = 1'b1;
    tick(H);
    sda_low_o = 1'b0;
    tick(H);
  endtask
  // sda released on a one, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = !b;
    tick(H);
    scl_o = 1'b1;
    tick(H);
    r = sda_i;
    scl_o = 1'b0;
    tick(H);
  endtask
  // byte msb first, then ack slot; ack_i low acks a read byte
  task automatic xfer(input logic [7:0] d, input logic ack_i,
                      output logic [7:0] q, output logic ack_o);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_i, ack_o);
  endtask
endmodule // srt_host

// [testbench/srt_target_test.sv]
// self-checking bench for the serial register access target
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("BAD %0t got %h want %h", $time, a, b); \
  end \
end
module srt_target_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] strap = 4'hA;
  logic [1:0] mode_sel = 2'h1;
  logic irq_active = 1'b0;
  logic [7:0] mem [256];
  logic scl;
  logic sda_low;
  logic sda_oe;
  logic sda_out;
  logic we;
  logic [7:0] raddr;
  logic [7:0] waddr;
  logic [7:0] wdata;
  // pull-up when nobody drives; the target may only ever pull low
  wire sda = !sda_low && !(sda_oe && !sda_out);
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam logic [7:0] OWN_W = 8'h54;  // prefix 010, straps 1010
  initial forever #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (we) mem[waddr] <= wdata;
  srt_host u_srt_host (
    .core_clk_i(core_clk_i),
    .sda_i(sda),
    .scl_o(scl),
    .sda_low_o(sda_low)
  );
  // short timeout keeps the stall scenario brief
  srt_target #(
    .TIMEOUT_CYC(200)
  ) u_srt_target (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_out),
    .sda_oe_o(sda_oe),
    .strap_addr_bit3_i(strap[3]),
    .strap_addr_bit2_i(strap[2]),
    .strap_addr_bit1_i(strap[1]),
    .strap_addr_bit0_i(strap[0]),
    .mode_sel_i(mode_sel),
    .irq_active_i(irq_active),
    .reg_rdata_i(mem[raddr]),
    .reg_addr_o(raddr),
    .reg_waddr_o(waddr),
    .reg_wdata_o(wdata),
    .reg_we_o(we)
  );
  // ----------------------------------------
  // helpers and scenarios
  // ----------------------------------------
  task automatic sb(input logic [7:0] d, input logic ack_exp);
    logic [7:0] q;
    logic a;
    u_srt_host.xfer(d, 1'b1, q, a);
    `CHK(a, ack_exp)
  endtask
  task automatic rb(input logic ack, input logic [7:0] exp);
    logic [7:0] q;
    logic a;
    u_srt_host.xfer(8'hFF, ack, q, a);
    `CHK(q, exp)
  endtask
  task automatic t_write();
    u_srt_host.start();
    sb(OWN_W, 1'b0);
    sb(8'h10, 1'b0);
    sb(8'hA5, 1'b0);
    sb(8'h3C, 1'b0);
    u_srt_host.stop();
    `CHK(mem[8'h10], 8'hA5)
    `CHK(mem[8'h11], 8'h3C)
  endtask
  task automatic t_read();
    u_srt_host.start();
    sb(OWN_W, 1'b0);
    sb(8'h10, 1'b0);
    u_srt_host.start();
    sb(OWN_W | 8'h01, 1'b0);
    rb(1'b0, 8'hA5);
    rb(1'b1, 8'h3C);
    u_srt_host.stop();
  endtask
  task automatic t_short();
    u_srt_host.start();
    sb(OWN_W | 8'h01, 1'b0);
    rb(1'b0, 8'h5A);
    rb(1'b1, 8'h96);
    u_srt_host.stop();
  endtask
  // passive until stop, even across a repeated start
  task automatic t_miss();
    u_srt_host.start();
    sb(8'h56, 1'b1);
    sb(8'h40, 1'b1);
    u_srt_host.start();
    sb(OWN_W, 1'b1);
    u_srt_host.stop();
    `CHK(mem[8'h40], 8'h00)
  endtask
  task automatic t_bcast();
    logic [1:0] m [3] = '{2'h0, 2'h1, 2'h3};
    logic [7:0] g;
    for (int i = 0; i < 3; i++) begin
      mode_sel = m[i];
      g = (m[i] == 2'h0) ? 8'h00 : 8'h60;
      u_srt_host.start();
      sb(g, 1'b0);
      sb(8'h20 + 8'(i), 1'b0);
      sb(8'hC0 + 8'(i), 1'b0);
      u_srt_host.stop();
      `CHK(mem[8'h20 + 8'(i)], 8'hC0 + 8'(i))
      u_srt_host.start();
      sb(g | 8'h01, 1'b1);
      u_srt_host.stop();
      u_srt_host.start();
      sb(g ^ 8'h60, 1'b1);
      u_srt_host.stop();
    end
  endtask
  task automatic t_alert();
    mode_sel = 2'h1;
    irq_active = 1'b1;
    u_srt_host.start();
    sb(8'h19, 1'b0);
    rb(1'b1, OWN_W);
    u_srt_host.stop();
    mode_sel = 2'h0;
    u_srt_host.start();
    sb(8'h19, 1'b1);
    u_srt_host.stop();
    mode_sel = 2'h1;
    irq_active = 1'b0;
    u_srt_host.start();
    sb(8'h19, 1'b1);
    u_srt_host.stop();
  endtask
  // scl held low while the ack is driven
  task automatic t_tmo();
    logic q;
    u_srt_host.start();
    for (int i = 7; i >= 0; i--) u_srt_host.bit_x(OWN_W[i], q);
    `CHK(sda_oe, 1'b1)
    u_srt_host.tick(150);
    `CHK(sda_oe, 1'b1)
    u_srt_host.tick(100);
    `CHK(sda_oe, 1'b0)
    u_srt_host.stop();
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      $display("BAD %0t hang guard reached", $time);
      end_sim();
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    mem[0] = 8'h5A;
    mem[1] = 8'h96;
    repeat (16) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    u_srt_host.tick(10);
    t_write();
    t_read();
    t_short();
    t_miss();
    t_bcast();
    t_alert();
    t_tmo();
    t_write();  // recovery after the abort
    end_sim();
  end
endmodule // srt_target_test
